/* verilog/sotpl_loader.sv */
// serial otp program loader: boot handshake, timed write, verify
`include "sotpl_defines.svh"
`default_nettype none

module sotpl_loader #(
  parameter int DEPTH = `SOTPL_MEM_DEPTH,
  parameter int PULSE_CYC = (`SOTPL_PULSE_NS / 1000) * (`SOTPL_CLK_HZ / 1000000),
  parameter int TIMEOUT_CYC = (`SOTPL_TIMEOUT_NS / 1000) * (`SOTPL_CLK_HZ / 1000000)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [15:0] baud_div,
  output logic baud_load,
  output logic hv_enable_line,
  output logic cpu_halt,
  output logic app_run,
  output logic [15:0] exec_addr,
  output var sotpl_pkg::sotpl_word_t table_word,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] BAUD_DIV = 16'(`SOTPL_CLK_HZ / `SOTPL_BAUD);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sotpl_pkg::sotpl_state_t state_q, state_d;
  sotpl_pkg::sotpl_word_t word_q, word_d;
  logic [31:0] cnt_q, cnt_d;
  logic [1:0] idx_q, idx_d;
  logic [15:0] exec_q, exec_d, baud_q, baud_d, rd_q, rd_d;
  logic hv_q, hv_d, halt_q, halt_d, run_q, run_d, bload_q, bload_d;
  logic push, push_ready, lw_done, wait_expired, in_range, match;
  logic [7:0] push_byte;
  logic [15:0] mem_q [DEPTH];
  logic [15:0] mem_d [DEPTH];
  logic [15:0] ptr_word;
  logic [31:0] assembled;

  assign in_range = (word_q.table_pointer < 16'(DEPTH));
  assign ptr_word = mem_q[word_q.table_pointer[AW-1:0]];
  assign match = in_range && (ptr_word == word_q.table_latch);
  assign wait_expired = (cnt_q == 32'(TIMEOUT_CYC - 1));
  assign lw_done = (state_q == sotpl_pkg::ST_WRITE) && (cnt_q == 32'(PULSE_CYC - 2));
  assign assembled = {word_q[23:0], rx_data};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    exec_d = exec_q;
    baud_d = baud_q;
    run_d = run_q;
    bload_d = 1'b0;
    rx_ready = 1'b0;
    push = 1'b0;
    push_byte = `SOTPL_REQ_BYTE;
    case (state_q)
      sotpl_pkg::ST_REQ: begin
        baud_d = BAUD_DIV;
        push = 1'b1;
        if (push_ready) begin
          bload_d = 1'b1;
          cnt_d = 32'h0;
          state_d = sotpl_pkg::ST_WAIT;
        end
      end
      sotpl_pkg::ST_WAIT: begin
        rx_ready = 1'b1;
        cnt_d = cnt_q + 32'h1;
        if (rx_valid && rx_data == `SOTPL_HOST_ACK) begin
          state_d = sotpl_pkg::ST_CMD;
        end else if (wait_expired) begin
          exec_d = `SOTPL_APP_BASE;
          run_d = 1'b1;
          state_d = sotpl_pkg::ST_RUN;
        end
      end
      sotpl_pkg::ST_CMD: begin
        rx_ready = 1'b1;
        idx_d = 2'h0;
        if (rx_valid && rx_data == `SOTPL_CMD_WRITE) begin
          state_d = sotpl_pkg::ST_RX;
        end else if (rx_valid && rx_data == `SOTPL_CMD_DONE) begin
          exec_d = `SOTPL_APP_BASE;
          run_d = 1'b1;
          state_d = sotpl_pkg::ST_RUN;
        end
      end
      sotpl_pkg::ST_RX: begin
        rx_ready = 1'b1;
        if (rx_valid) begin
          word_d = assembled;
          idx_d = idx_q + 2'h1;
          if (idx_q == `SOTPL_LAST_BYTE) begin
            state_d = sotpl_pkg::ST_HV_ON;
          end
        end
      end
      sotpl_pkg::ST_HV_ON: begin
        cnt_d = 32'h0;
        state_d = sotpl_pkg::ST_WRITE;
      end
      sotpl_pkg::ST_WRITE: begin
        cnt_d = cnt_q + 32'h1;
        if (lw_done) begin
          state_d = sotpl_pkg::ST_HV_OFF;
        end
      end
      sotpl_pkg::ST_HV_OFF: begin
        state_d = sotpl_pkg::ST_VERIFY;
      end
      sotpl_pkg::ST_VERIFY: begin
        push = 1'b1;
        push_byte = match ? `SOTPL_DEV_ACK : `SOTPL_DEV_NAK;
        if (push_ready) begin
          state_d = sotpl_pkg::ST_CMD;
        end
      end
      sotpl_pkg::ST_RUN: begin
        run_d = 1'b1;
      end
      default: begin
        state_d = sotpl_pkg::ST_REQ;
      end
    endcase
    // hv stays low exactly while in ST_HV_ON or ST_WRITE, so pulse length is counted
    hv_d = !(state_d == sotpl_pkg::ST_HV_ON || state_d == sotpl_pkg::ST_WRITE);
    halt_d = (state_d == sotpl_pkg::ST_WRITE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= sotpl_pkg::ST_REQ;
      word_q <= '0;
      cnt_q <= 32'h0;
      idx_q <= 2'h0;
      exec_q <= `SOTPL_BOOT_BASE;
      baud_q <= BAUD_DIV;
      run_q <= 1'b0;
      bload_q <= 1'b0;
      hv_q <= 1'b1;
      halt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      exec_q <= exec_d;
      baud_q <= baud_d;
      run_q <= run_d;
      bload_q <= bload_d;
      hv_q <= hv_d;
      halt_q <= halt_d;
    end
  end

  // ----------------------------------------------------------------
  // otp array
  // ----------------------------------------------------------------
  // reset stands in for a blank part; a real array keeps its contents
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    assign mem_d[i] = (lw_done && word_q.table_pointer[AW-1:0] == AW'(i) && in_range) ?
                      (mem_q[i] & word_q.table_latch) : mem_q[i];
    always_ff @(posedge clock) begin
      if (rst) begin
        mem_q[i] <= `SOTPL_BLANK;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_comb begin
    rd_d = (rd_addr < 16'(DEPTH)) ? mem_q[rd_addr[AW-1:0]] : `SOTPL_BLANK;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_q <= `SOTPL_BLANK;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------
  sotpl_buf2 #(.W(8)) u_txbuf (
    .clock(clock),
    .rst(rst),
    .in_valid(push),
    .in_data(push_byte),
    .in_ready(push_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  assign baud_div = baud_q;
  assign baud_load = bload_q;
  assign hv_enable_line = hv_q;
  assign cpu_halt = halt_q;
  assign app_run = run_q;
  assign exec_addr = exec_q;
  assign table_word = word_q;
  assign rd_data = rd_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [31:0] hv_low_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      hv_low_q <= 32'h0;
    end else begin
      hv_low_q <= hv_enable_line ? 32'h0 : hv_low_q + 32'h1;
    end
  end

  sequence s_write_start;
    state_q == sotpl_pkg::ST_HV_ON ##1 state_q == sotpl_pkg::ST_WRITE;
  endsequence

  property p_boot_entry;
    $fell(rst) |-> exec_addr == `SOTPL_BOOT_BASE && !app_run && hv_enable_line;
  endproperty
  a_boot_entry: assert property (p_boot_entry) else $error("not in loader after reset");

  property p_request_first;
    $fell(rst) |-> ##[1:4] (tx_valid && tx_data == `SOTPL_REQ_BYTE && baud_div == BAUD_DIV);
  endproperty
  a_request_first: assert property (p_request_first) else $error("no request sent");

  property p_load_pair;
    state_q == sotpl_pkg::ST_RX && rx_valid && idx_q == `SOTPL_LAST_BYTE |=>
      table_word == $past(assembled) && !hv_enable_line;
  endproperty
  a_load_pair: assert property (p_load_pair) else $error("pair not loaded");

  property p_hv_during_write;
    s_write_start |-> !hv_enable_line && cpu_halt;
  endproperty
  a_hv_during_write: assert property (p_hv_during_write) else $error("hv or halt wrong");

  property p_resume;
    lw_done |=> !cpu_halt && hv_enable_line ##1 state_q == sotpl_pkg::ST_VERIFY;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after write");

  property p_pulse_max;
    hv_low_q <= 32'(PULSE_CYC);
  endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");

  property p_verify_hv_off;
    state_q == sotpl_pkg::ST_VERIFY |-> hv_enable_line && !cpu_halt;
  endproperty
  a_verify_hv_off: assert property (p_verify_hv_off) else $error("verify with hv on");

  property p_ack_on_match;
    state_q == sotpl_pkg::ST_VERIFY && push_ready && match |->
      push && push_byte == `SOTPL_DEV_ACK ##1 state_q == sotpl_pkg::ST_CMD;
  endproperty
  a_ack_on_match: assert property (p_ack_on_match) else $error("no ack step");

  property p_timeout;
    state_q == sotpl_pkg::ST_WAIT && wait_expired && !(rx_valid && rx_data == `SOTPL_HOST_ACK)
      |=> app_run && exec_addr == `SOTPL_APP_BASE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no fall-through");

  property p_clear_only;
    lw_done && in_range |=> ptr_word == ($past(ptr_word) & $past(word_q.table_latch));
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("bit set by write");

endmodule

`default_nettype wire

/* verilog/sotpl_defines.svh */
// constants of the serial otp program loader
`ifndef SOTPL_DEFINES_SVH
`define SOTPL_DEFINES_SVH

// ----------------------------------------------------------------
// memory map
// ----------------------------------------------------------------
`define SOTPL_BOOT_BASE 16'h0700
`define SOTPL_APP_BASE 16'h0000
`define SOTPL_BLANK 16'hffff
`define SOTPL_MEM_DEPTH 2048

// ----------------------------------------------------------------
// link bytes
// ----------------------------------------------------------------
`define SOTPL_REQ_BYTE 8'h3f
`define SOTPL_HOST_ACK 8'h06
`define SOTPL_DEV_ACK 8'h06
`define SOTPL_DEV_NAK 8'h15
`define SOTPL_CMD_WRITE 8'h01
`define SOTPL_CMD_DONE 8'h04
`define SOTPL_LAST_BYTE 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SOTPL_CLK_HZ 40000000
`define SOTPL_BAUD 9600
`define SOTPL_PULSE_NS 1000000
`define SOTPL_TIMEOUT_NS 100000000

`endif

/* verilog/sotpl_pkg.sv */
// types of the serial otp program loader
`default_nettype none

package sotpl_pkg;

  typedef enum logic [8:0] {
    ST_REQ = 9'h001,
    ST_WAIT = 9'h002,
    ST_CMD = 9'h004,
    ST_RX = 9'h008,
    ST_HV_ON = 9'h010,
    ST_WRITE = 9'h020,
    ST_HV_OFF = 9'h040,
    ST_VERIFY = 9'h080,
    ST_RUN = 9'h100
  } sotpl_state_t;

  typedef struct packed {
    logic [15:0] table_pointer;
    logic [15:0] table_latch;
  } sotpl_word_t;

endpackage

`default_nettype wire

/* verilog/sotpl_buf2.sv */
// two-entry valid/ready buffer
`default_nettype none

module sotpl_buf2 #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    case ({push, pop})
      2'b10: cnt_d = cnt_q + 2'h1;
      2'b01: cnt_d = cnt_q - 2'h1;
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end

endmodule

`default_nettype wire

/* dv/sotpl_host.sv */
// host model: programming station on the far side of the loader link
`default_nettype none

module sotpl_host (
  input wire logic clock,
  input wire logic rst,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hff;
    tx_ready = 1'b0;
  end

  // ----------------------------------------------------------------
  // receive side: collects every byte the loader sends
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    tx_ready <= ~stall;
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
    end
  end

  // ----------------------------------------------------------------
  // send side: held until taken, then the data line is scrambled
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clock);
    while (rx_ready !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    rx_valid <= 1'b0;
    // inverse, so a stale byte is never mistaken for a fresh one
    rx_data <= ~b;
  endtask

  task automatic ack();
    send(8'h06);
  endtask

  task automatic frame(input logic [15:0] a, input logic [15:0] d);
    send(8'h01);
    send(a[15:8]);
    send(a[7:0]);
    send(d[15:8]);
    send(d[7:0]);
  endtask
endmodule

`default_nettype wire

/* dv/sotpl_loader_tb.sv */
// self-checking testbench of the serial otp program loader
`default_nettype none

module sotpl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PULSE = 8;
  localparam int TMO = 50;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic stall = 1'b0;
  logic [15:0] rd_addr = 16'h0000;
  logic rx_valid, rx_ready, tx_valid, tx_ready, baud_load, hv_enable_line, cpu_halt, app_run;
  logic [7:0] rx_data, tx_data;
  logic [15:0] baud_div, exec_addr, rd_data;
  sotpl_pkg::sotpl_word_t table_word;
  int fail_count = 0;
  int n_tests = 0;
  int hv_low = 0;
  int halt_hi = 0;
  int loads = 0;
  int overlap = 0;

  always #12.5 clock = ~clock;

  sotpl_loader #(.DEPTH(16), .PULSE_CYC(PULSE), .TIMEOUT_CYC(TMO)) sotpl_loader_i (
    .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .baud_div(baud_div),
    .baud_load(baud_load), .hv_enable_line(hv_enable_line), .cpu_halt(cpu_halt),
    .app_run(app_run), .exec_addr(exec_addr), .table_word(table_word), .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  sotpl_host sotpl_host_i (
    .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .stall(stall)
  );

  // ----------------------------------------------------------------
  // monitors and compare tasks
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      hv_low <= 0;
      halt_hi <= 0;
      loads <= 0;
    end else begin
      if (hv_enable_line === 1'b0) hv_low <= hv_low + 1;
      if (cpu_halt === 1'b1) halt_hi <= halt_hi + 1;
      if (baud_load === 1'b1) loads <= loads + 1;
      // halted core without high voltage would be a wasted pulse
      if (cpu_halt === 1'b1 && hv_enable_line !== 1'b0) overlap <= overlap + 1;
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t: flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    sotpl_host_i.got.delete();
    rst <= 1'b0;
  endtask

  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (sotpl_host_i.got.size() < n && k < 300) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk1(sotpl_host_i.got.size() >= n, 1'b1);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    rd_addr <= a;
    repeat (2) @(posedge clock);
    #1;
    chk16(rd_data, e);
  endtask

  task automatic wr(input logic [15:0] a, d, input logic [7:0] e, input logic hv, stl);
    int h0, t0, n;
    h0 = hv_low;
    t0 = halt_hi;
    n = sotpl_host_i.got.size();
    if (stl) stall <= 1'b1;
    sotpl_host_i.frame(a, d);
    if (stl) begin
      repeat (PULSE + 20) @(posedge clock);
      #1;
      chk1(tx_valid, 1'b1);
      chk16({8'h00, tx_data}, {8'h00, e});
      @(posedge clock);
      stall <= 1'b0;
    end
    wait_tx(n + 1);
    chk16({8'h00, sotpl_host_i.got[n]}, {8'h00, e});
    chk16(table_word.table_pointer, a);
    chk16(table_word.table_latch, d);
    chk1(hv_enable_line, 1'b1);
    if (hv) begin
      chk16(16'(hv_low - h0), 16'(PULSE));
      chk1(halt_hi > t0 && halt_hi - t0 <= PULSE, 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    do_reset();
    @(posedge clock);
    #1;
    chk1(hv_enable_line, 1'b1);
    chk1(app_run, 1'b0);
    chk16(exec_addr, 16'h0700);
    chk16(baud_div, 16'h1046);
    wait_tx(1);
    chk16({8'h00, sotpl_host_i.got[0]}, 16'h003f);
    chk16(16'(loads), 16'h0001);
    rd_chk(16'h0005, 16'hffff);
    rd_chk(16'h0040, 16'hffff);
  endtask

  task automatic t_timeout();
    do_reset();
    repeat (TMO - 5) @(posedge clock);
    #1;
    chk1(app_run, 1'b0);
    repeat (40) @(posedge clock);
    #1;
    chk1(app_run, 1'b1);
    chk16(exec_addr, 16'h0000);
    chk1(hv_enable_line, 1'b1);
    chk1(rx_ready, 1'b0);
  endtask

  task automatic t_prog();
    do_reset();
    sotpl_host_i.send(8'h55);
    sotpl_host_i.ack();
    sotpl_host_i.send(8'h77);
    wr(16'h0003, 16'h1234, 8'h06, 1'b1, 1'b0);
    rd_chk(16'h0003, 16'h1234);
    wr(16'h0005, 16'ha5a5, 8'h06, 1'b1, 1'b1);
    rd_chk(16'h0005, 16'ha5a5);
    wr(16'h0003, 16'h0000, 8'h06, 1'b1, 1'b0);
    rd_chk(16'h0003, 16'h0000);
    wr(16'h0003, 16'hffff, 8'h15, 1'b1, 1'b0);
    rd_chk(16'h0003, 16'h0000);
    wr(16'h0020, 16'h1111, 8'h15, 1'b0, 1'b0);
    chk1(app_run, 1'b0);
    chk16(exec_addr, 16'h0700);
    chk16(16'(overlap), 16'h0000);
    sotpl_host_i.send(8'h04);
    @(posedge clock);
    #1;
    chk1(app_run, 1'b1);
    chk16(exec_addr, 16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    complete_run();
  end

  initial begin
    t_boot();
    t_timeout();
    t_prog();
    complete_run();
  end
endmodule

`default_nettype wire
